//--- rtl/pwi_pkg.sv
/*
 Package for the parallel word I/O port: register offsets, the control/status
 field layout, reset values, event bit positions and timing constants.
 Assumes a 250 MHz system clock and a 32-bit Avalon-MM register bus.
*/
package pwi_pkg;

	// Data path widths
	localparam int WORD_W      = 16;         // Output and input word width
	localparam int ADDR_W      = 5;          // Byte address width of the slave
	localparam int EVT_W       = 4;          // Number of sticky event bits

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CSR      = 5'h00; // Control/status
	localparam logic [ADDR_W-1:0] OFS_OUTBUF   = 5'h04; // Output buffer
	localparam logic [ADDR_W-1:0] OFS_INBUF    = 5'h08; // Input buffer
	localparam logic [ADDR_W-1:0] OFS_EVT_STAT = 5'h0C; // Sticky events, read clears
	localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 5'h10; // Event mask
	localparam logic [ADDR_W-1:0] OFS_VECTOR   = 5'h14; // Level and vector, read only

	// Byte enable patterns for the output buffer
	localparam logic [3:0] BE_LOW  = 4'h1;   // Low byte only
	localparam logic [3:0] BE_HIGH = 4'h2;   // High byte only

	// Control/status register layout, bit 15 down to bit 0
	typedef struct packed {
		logic       req_b;       // Second request flag, bit 15
		logic [4:0] rsv_hi;      // Reads as zero
		logic [1:0] user_stat;   // User status lines from the device
		logic       req_a;       // First request flag, bit 7
		logic       ie_a;        // First interrupt enable, bit 6
		logic       ie_b;        // Second interrupt enable, bit 5
		logic       loopback;    // Maintenance loopback
		logic [1:0] rsv_lo;      // Reads as zero
		logic [1:0] user_cmd;    // User command lines to the device
	} pwi_csr_type;

	// Writable control/status bits
	localparam logic [WORD_W-1:0] CSR_WR_MASK = 16'h0073;
	localparam logic [WORD_W-1:0] CSR_RESET   = 16'h0000;

	// Vectored request as seen by the host interrupt logic
	typedef struct packed {
		logic       req;         // Request level
		logic [2:0] level;       // Priority level
		logic [8:0] vector;      // Vector address
	} pwi_irq_type;

	// Sticky event positions
	localparam int EVT_REQ_A   = 0;          // Request A rose
	localparam int EVT_REQ_B   = 1;          // Request B rose
	localparam int EVT_NEWDATA = 2;          // New-data strobe sent
	localparam int EVT_TAKEN   = 3;          // Input-taken strobe sent
	localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;

	// Interrupt defaults, changeable by the integrator
	localparam logic [2:0] IRQ_LEVEL_DEF  = 3'h5;   // Priority level 5
	localparam logic [8:0] IRQ_VECTOR_DEF = 9'h0C0; // Vector 300 octal
	localparam logic [8:0] IRQ_VEC_STEP   = 9'h004; // Second request vector offset

	// Timing
	localparam int CLK_MHZ      = 250;       // System clock rate
	localparam int STROBE_NS    = 400;       // Strobe pulse width
	localparam int STROBE_CYC   = (STROBE_NS * CLK_MHZ + 999) / 1000;

endpackage

//--- rtl/pwi_port.sv
/*
 Parallel word I/O port: control/status, output buffer and input buffer
 registers behind an Avalon-MM slave, 16 output lines with a new-data
 strobe, 16 input lines with an input-taken strobe, two device request
 lines raising a vectored interrupt, and a maintenance loopback.
 Assumes the device lines are asynchronous to clk; all are synchronised.
*/
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
module pwi_port #(
	parameter int         STROBE_CYC = pwi_pkg::STROBE_CYC,     // Strobe width in cycles
	parameter logic [2:0] IRQ_LEVEL  = pwi_pkg::IRQ_LEVEL_DEF,  // Priority plug
	parameter logic [8:0] IRQ_VECTOR = pwi_pkg::IRQ_VECTOR_DEF  // Vector switches
) (
	input  wire logic                             clk,
	input  wire logic                             rst_b,
	// Avalon-MM slave
	input  wire logic [pwi_pkg::ADDR_W-1:0]       avs_address,
	input  wire logic                             avs_read,
	input  wire logic                             avs_write,
	input  wire logic [31:0]                      avs_writedata,
	input  wire logic [3:0]                       avs_byteenable,
	output logic [31:0]                           avs_readdata,
	output logic                                  avs_waitrequest,
	// Device side
	output logic [pwi_pkg::WORD_W-1:0]            data_out,
	output logic                                  new_data_strobe,
	input  wire logic [pwi_pkg::WORD_W-1:0]       data_in,
	output logic                                  input_taken_strobe,
	input  wire logic                             req_a_in,
	input  wire logic                             req_b_in,
	output logic [1:0]                            user_cmd,
	input  wire logic [1:0]                       user_stat_in,
	output logic                                  init_out,
	// Interrupts
	output pwi_pkg::pwi_irq_type                  vec_irq,
	output logic                                  irq
);

	localparam int W = pwi_pkg::WORD_W;

	// Bus handshake state
	logic        done_reg;          // High in the answering cycle
	logic [31:0] rdata_reg;         // Registered read data
	logic [31:0] rdata_next;        // Read data mux
	logic        req_any;           // A read or write is present
	logic        wr_take;           // Write takes effect this edge
	logic        rd_take;           // Read is taken this edge

	// Registers
	pwi_pkg::pwi_csr_type csr_reg;  // Control/status view
	logic [W-1:0]         ctl_reg;  // Writable control bits
	logic [W-1:0]         ctl_next;
	logic [W-1:0]         out_reg;  // Output buffer
	logic [W-1:0]         out_next;
	logic [W-1:0]         in_reg;   // Input buffer
	logic [W-1:0]         in_next;
	logic [pwi_pkg::EVT_W-1:0] evt_reg;   // Sticky events
	logic [pwi_pkg::EVT_W-1:0] evt_next;
	logic [pwi_pkg::EVT_W-1:0] evt_set;   // Events this cycle
	logic [pwi_pkg::EVT_W-1:0] evt_clr;   // Bits handed out by a status read
	logic [pwi_pkg::EVT_W-1:0] mask_reg;  // Event mask

	// Synchronisers: first stage is read by the second stage only
	logic [W-1:0] din_s1_reg;
	logic [W-1:0] din_s2_reg;
	logic [3:0]   ctl_s1_reg;       // user status, req_b, req_a
	logic [3:0]   ctl_s2_reg;
	logic [1:0]   req_d_reg;        // Previous synchronised requests

	// Address decode
	logic sel_csr;
	logic sel_out;
	logic sel_in;
	logic sel_stat;
	logic sel_mask;
	logic sel_vec;

	// Strobe triggers
	logic fire_new;
	logic fire_taken;

	// Interrupt terms
	logic req_a_s;
	logic req_b_s;
	logic irq_a;
	logic irq_b;
	logic init_reg;

	// Bus handshake: answer one cycle after the request appears
	assign req_any         = avs_read | avs_write;
	assign avs_waitrequest = req_any & ~done_reg;
	assign wr_take         = avs_write & done_reg;
	assign rd_take         = avs_read & done_reg;

	// Decode on the full byte address
	assign sel_csr  = (avs_address == pwi_pkg::OFS_CSR);
	assign sel_out  = (avs_address == pwi_pkg::OFS_OUTBUF);
	assign sel_in   = (avs_address == pwi_pkg::OFS_INBUF);
	assign sel_stat = (avs_address == pwi_pkg::OFS_EVT_STAT);
	assign sel_mask = (avs_address == pwi_pkg::OFS_EVT_MASK);
	assign sel_vec  = (avs_address == pwi_pkg::OFS_VECTOR);

	// Synchronised device levels
	assign req_a_s = ctl_s2_reg[0];
	assign req_b_s = ctl_s2_reg[1];

	// Control/status view: enables from software, flags from the device
	always_comb begin
		csr_reg           = pwi_pkg::pwi_csr_type'(ctl_reg);
		csr_reg.req_a     = req_a_s;
		csr_reg.req_b     = req_b_s;
		csr_reg.user_stat = ctl_s2_reg[3:2];
		csr_reg.rsv_hi    = '0;
		csr_reg.rsv_lo    = '0;
	end

	// Only enables, loopback and command bits are writable
	assign ctl_next = (wr_take && sel_csr) ?
		((avs_writedata[W-1:0] & pwi_pkg::CSR_WR_MASK) |
		 (ctl_reg & ~pwi_pkg::CSR_WR_MASK)) : ctl_reg;

	// Output buffer with byte lanes; either lane alone leaves the other unchanged
	always_comb begin
		out_next = out_reg;
		if (wr_take && sel_out) begin
			if (avs_byteenable[0]) begin
				out_next[7:0] = avs_writedata[7:0];
			end
			if (avs_byteenable[1]) begin
				out_next[15:8] = avs_writedata[15:8];
			end
		end
	end

	// Any write that touches the output buffer lanes counts as new data
	assign fire_new = wr_take & sel_out & (|avs_byteenable[1:0]);

	// Input buffer follows the lines, or the output buffer in loopback
	assign in_next = ctl_reg[4] ? out_reg : din_s2_reg;

	// Reading the input buffer tells the device its word was taken
	assign fire_taken = rd_take & sel_in;

	// Event sources, rising requests sampled after synchronisation
	assign evt_set[pwi_pkg::EVT_REQ_A]   = req_a_s & ~req_d_reg[0];
	assign evt_set[pwi_pkg::EVT_REQ_B]   = req_b_s & ~req_d_reg[1];
	assign evt_set[pwi_pkg::EVT_NEWDATA] = fire_new;
	assign evt_set[pwi_pkg::EVT_TAKEN]   = fire_taken;

	// Read clears only the bits it returned; the snapshot is one cycle old,
	// so an event landing in the wait cycle stays pending for the next read
	assign evt_clr  = (rd_take && sel_stat) ? rdata_reg[pwi_pkg::EVT_W-1:0] : '0;
	assign evt_next = (evt_reg & ~evt_clr) | evt_set;

	// Read data mux; unmapped addresses read zero
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (sel_csr) begin
			rdata_next[W-1:0] = csr_reg;
		end else if (sel_out) begin
			rdata_next[W-1:0] = out_reg;
		end else if (sel_in) begin
			rdata_next[W-1:0] = in_reg;
		end else if (sel_stat) begin
			rdata_next[pwi_pkg::EVT_W-1:0] = evt_reg;
		end else if (sel_mask) begin
			rdata_next[pwi_pkg::EVT_W-1:0] = mask_reg;
		end else if (sel_vec) begin
			rdata_next[11:0] = {IRQ_LEVEL, IRQ_VECTOR};
		end
	end

	// Handshake and read data register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			done_reg  <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			done_reg  <= req_any & ~done_reg;
			rdata_reg <= rdata_next;
		end
	end

	// Data captured in the waiting cycle stands in the answer cycle
	assign avs_readdata = rdata_reg;

	// Software registers; initialize clears the enables
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctl_reg  <= pwi_pkg::CSR_RESET;
			out_reg  <= '0;
			mask_reg <= '0;
		end else begin
			ctl_reg  <= ctl_next;
			out_reg  <= out_next;
			if (wr_take && sel_mask) begin
				mask_reg <= avs_writedata[pwi_pkg::EVT_W-1:0];
			end
		end
	end

	// Input buffer and sticky events
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			in_reg  <= '0;
			evt_reg <= pwi_pkg::EVT_RESET;
		end else begin
			in_reg  <= in_next;
			evt_reg <= evt_next;
		end
	end

	// Two-stage synchronisers; reset leaves request flags clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			din_s1_reg <= '0;
			din_s2_reg <= '0;
			ctl_s1_reg <= '0;
			ctl_s2_reg <= '0;
			req_d_reg  <= '0;
		end else begin
			din_s1_reg <= data_in;
			din_s2_reg <= din_s1_reg;
			ctl_s1_reg <= {user_stat_in, req_b_in, req_a_in};
			ctl_s2_reg <= ctl_s1_reg;
			req_d_reg  <= {req_b_s, req_a_s};
		end
	end

	// Initialize level to both connectors, released one edge after reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			init_reg <= 1'b1;
		end else begin
			init_reg <= 1'b0;
		end
	end

	// Strobe one-shots
	pwi_pulse #(
		.WIDTH (STROBE_CYC)
	) u_new_strobe (
		.clk   (clk),
		.rst_b (rst_b),
		.fire  (fire_new),
		.pulse (new_data_strobe)
	);

	pwi_pulse #(
		.WIDTH (STROBE_CYC)
	) u_taken_strobe (
		.clk   (clk),
		.rst_b (rst_b),
		.fire  (fire_taken),
		.pulse (input_taken_strobe)
	);

	// Vectored request: each flag gated by its own enable
	assign irq_a = csr_reg.ie_a & csr_reg.req_a;
	assign irq_b = csr_reg.ie_b & csr_reg.req_b;

	// Request A wins the vector when both are pending
	assign vec_irq.req    = irq_a | irq_b;
	assign vec_irq.level  = IRQ_LEVEL;
	assign vec_irq.vector = irq_a ? IRQ_VECTOR :
		9'(IRQ_VECTOR + pwi_pkg::IRQ_VEC_STEP);

	// Event interrupt level
	assign irq = |(evt_reg & mask_reg);

	// Device lines come straight from registers
	assign data_out = out_reg;
	assign user_cmd = csr_reg.user_cmd;
	assign init_out = init_reg;

endmodule

//--- rtl/pwi_pulse.sv
/*
 One-shot strobe generator: a one-cycle fire input starts a positive pulse
 of WIDTH clock cycles. Assumes fire is synchronous to clk.
*/
`timescale 1ns/1ns
module pwi_pulse #(
	parameter int WIDTH = pwi_pkg::STROBE_CYC
) (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic fire,
	output logic      pulse
);

	localparam int CNT_W = $clog2(WIDTH + 1);

	logic [CNT_W-1:0] count_reg;   // Cycles still to hold the pulse high
	logic [CNT_W-1:0] count_next;

	// A fresh fire restarts the full width, so back-to-back transfers still
	// show one clean pulse of at least the set width.
	assign count_next = fire ? CNT_W'(WIDTH) :
		(count_reg != '0) ? count_reg - CNT_W'(1) : count_reg;

	// Down counter
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

	// High while the counter runs
	assign pulse = (count_reg != '0);

endmodule

//--- tb/pwi_checker.sv
/*
 Checker for the parallel word I/O port, bound to each instance.
 Sees the port pins only; shadows the enables and mask from bus writes.
*/
`timescale 1ns/1ns
module pwi_checker #(
	parameter int         STROBE_CYC = pwi_pkg::STROBE_CYC,
	parameter logic [2:0] IRQ_LEVEL  = pwi_pkg::IRQ_LEVEL_DEF,
	parameter logic [8:0] IRQ_VECTOR = pwi_pkg::IRQ_VECTOR_DEF
) (
	input wire logic                       clk,
	input wire logic                       rst_b,
	input wire logic [pwi_pkg::ADDR_W-1:0] avs_address,
	input wire logic                       avs_read,
	input wire logic                       avs_write,
	input wire logic [31:0]                avs_writedata,
	input wire logic [3:0]                 avs_byteenable,
	input wire logic                       avs_waitrequest,
	input wire logic [pwi_pkg::WORD_W-1:0] data_out,
	input wire logic                       new_data_strobe,
	input wire logic                       input_taken_strobe,
	input wire logic                       req_a_in,
	input wire logic                       req_b_in,
	input wire logic                       init_out,
	input wire pwi_pkg::pwi_irq_type       vec_irq,
	input wire logic                       irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Accepted transfers, decoded from the bus pins
	wire acc = !avs_waitrequest;
	wire wr_out = avs_write && acc && avs_address == pwi_pkg::OFS_OUTBUF && |avs_byteenable[1:0];
	wire wr_csr = avs_write && acc && avs_address == pwi_pkg::OFS_CSR && avs_byteenable[0];
	wire wr_msk = avs_write && acc && avs_address == pwi_pkg::OFS_EVT_MASK && avs_byteenable[0];
	wire rd_in = avs_read && acc && avs_address == pwi_pkg::OFS_INBUF;
	logic [1:0] ie_reg;   // Shadow enables, A then B
	logic [3:0] mask_reg; // Shadow event mask
	logic [7:0] nd_reg;   // Cycles since last output write
	logic [7:0] tk_reg;   // Cycles since last input read
	// Counters run one past the width, so an overlong pulse is caught
	wire [7:0] nd_next = wr_out ? 8'h01 : (nd_reg != 0 && nd_reg <= STROBE_CYC) ? nd_reg + 1 : 8'h00;
	wire [7:0] tk_next = rd_in ? 8'h01 : (tk_reg != 0 && tk_reg <= STROBE_CYC) ? tk_reg + 1 : 8'h00;
	// Shadow state
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ie_reg <= 2'h0;
			mask_reg <= 4'h0;
			nd_reg <= 8'h00;
			tk_reg <= 8'h00;
		end else begin
			ie_reg <= wr_csr ? avs_writedata[6:5] : ie_reg;
			mask_reg <= wr_msk ? avs_writedata[3:0] : mask_reg;
			nd_reg <= nd_next;
			tk_reg <= tk_next;
		end
	end
	// Request lines held long enough to pass the synchroniser
	sequence a_held; req_a_in [*3]; endsequence
	sequence b_held; req_b_in [*3]; endsequence
	AST_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered after one wait cycle");
	AST_ND: assert property (new_data_strobe == (nd_reg != 0 && nd_reg <= STROBE_CYC))
		else $error("new-data strobe timing wrong");
	AST_TK: assert property (input_taken_strobe == (tk_reg != 0 && tk_reg <= STROBE_CYC))
		else $error("input-taken strobe timing wrong");
	AST_DOUT: assert property (!$stable(data_out) |-> $past(wr_out))
		else $error("output lines changed without a write");
	AST_NOIE: assert property (ie_reg == 2'h0 |-> !vec_irq.req)
		else $error("interrupt requested with both enables clear");
	AST_RQA: assert property (a_held ##0 ie_reg[1] |-> vec_irq.req && vec_irq.vector == IRQ_VECTOR)
		else $error("first request not raised");
	AST_RQB: assert property (b_held ##0 ie_reg[0] |-> vec_irq.req)
		else $error("second request not raised");
	AST_LVL: assert property (vec_irq.level == IRQ_LEVEL)
		else $error("priority level wrong");
	AST_INIT: assert property ($past(rst_b) |-> !init_out)
		else $error("initialize output stuck after reset");
	AST_MASK: assert property (mask_reg == 4'h0 |-> !irq)
		else $error("event interrupt while fully masked");
	AST_EVT: assert property (wr_out && mask_reg[2] |=> ##[0:2] irq)
		else $error("new-data event did not interrupt");
endmodule

//--- tb/pwi_dev_model.sv
/*
 Model of the user device on the far side of the port.
 Assumes the bench hands it words and request levels on clk.
*/
`timescale 1ns/1ns
module pwi_dev_model (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [15:0] dev_word,    // Word the device offers next
	input  wire logic [1:0]  dev_req,     // Request levels, B then A
	input  wire logic [1:0]  user_cmd,    // Command lines from the port
	output logic      [15:0] data_in,     // Input lines
	output logic             req_a_in,    // First request line
	output logic             req_b_in,    // Second request line
	output logic      [1:0]  user_stat_in // Status lines
);
	// Device logic; changes launch on clk like a synchronous peripheral
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			data_in <= 16'h0000;
			{req_b_in, req_a_in} <= 2'h0;
			user_stat_in <= 2'h0;
		end else begin
			data_in <= dev_word;
			{req_b_in, req_a_in} <= dev_req;
			user_stat_in <= user_cmd;
		end
	end
endmodule

//--- tb/tb_parallel_word_io_interface.sv
/*
 Bench for the parallel word I/O port: Avalon-MM master tasks, queued
 read checks, a device model and the bound checker.
 Assumes package, design, checker and model are compiled first.
*/
`timescale 1ns/1ns
module tb_parallel_word_io_interface;
	localparam int STB = 4; // Short strobe keeps the run brief
	logic                 clk;
	logic                 rst_b;
	logic [4:0]           avs_address;
	logic                 avs_read;
	logic                 avs_write;
	logic [31:0]          avs_writedata;
	logic [3:0]           avs_byteenable;
	logic [31:0]          avs_readdata;
	logic                 avs_waitrequest;
	logic [15:0]          data_out;
	logic                 new_data_strobe;
	logic [15:0]          data_in;
	logic                 input_taken_strobe;
	logic                 req_a_in;
	logic                 req_b_in;
	logic [1:0]           user_cmd;
	logic [1:0]           user_stat_in;
	logic                 init_out;
	pwi_pkg::pwi_irq_type vec_irq;
	logic                 irq;
	logic [15:0]          dev_word;  // Word handed to the device
	logic [1:0]           dev_req;   // Request levels for the device
	logic [31:0]          expq[$];   // Expected read data, oldest first
	logic [31:0]          d;         // Random write data
	logic [15:0]          ob;        // Expected output buffer
	logic [3:0]           be;        // Lanes of the current write
	int                   seed;
	int                   cyc;
	int                   miscompares;
	int                   samples_checked;

	pwi_port #(.STROBE_CYC(STB)) DUT (.*);
	pwi_dev_model dev (.*);

	// Free-running system clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task results;
		miscompares += expq.size();
		$display("checked %0d, wrong %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// One bus cycle; the leading edge keeps a gap after the last release
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] dt,
		input logic [3:0] lanes);
		@(posedge clk);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= dt;
		avs_byteenable <= lanes;
		// Hold until waitrequest is seen low at a rising edge; only the
		// bench timeout ends a wait that never completes
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		expq.push_back(e);
		bus(1'b0, a, 32'h0, 4'hF);
	endtask

	task automatic wt(input logic [4:0] a, input logic [31:0] dt, input logic [3:0] lanes);
		bus(1'b1, a, dt, lanes);
	endtask

	// Read watcher: data taken at the accepting rising edge
	always @(posedge clk)
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && expq.size() > 0)
			chk(avs_readdata, expq.pop_front());

	// Hang guard, far above the expected run of about a hundred cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			miscompares++;
			results();
		end
	end

	initial begin
		seed = 44;
		cyc = 0;
		miscompares = 0;
		samples_checked = 0;
		rst_b = 1'b0;
		{avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
		dev_word = 16'h0;
		dev_req = 2'h0;
		repeat (10) @(posedge clk);
		chk(32'(init_out), 32'h1);
		rst_b <= 1'b1;
		rd(pwi_pkg::OFS_CSR, 32'h0);
		rd(pwi_pkg::OFS_VECTOR, 32'h0AC0);
		rd(5'h18, 32'h0);
		// Event path: new-data event unmasked, then read-clear
		wt(pwi_pkg::OFS_EVT_MASK, 32'h4, 4'hF);
		d = $random(seed);
		ob = d[15:0];
		wt(pwi_pkg::OFS_OUTBUF, d, 4'h3);
		repeat (2) @(negedge clk);
		chk(32'(data_out), 32'(ob));
		chk(32'(irq), 32'h1);
		rd(pwi_pkg::OFS_EVT_STAT, 32'h4);
		@(negedge clk);
		chk(32'(irq), 32'h0);
		// Low, high and word writes back to back
		for (int i = 0; i < 3; i++) begin
			d = $random(seed);
			be = (i == 0) ? pwi_pkg::BE_LOW : (i == 1) ? pwi_pkg::BE_HIGH : 4'h3;
			ob = {be[1] ? d[15:8] : ob[15:8], be[0] ? d[7:0] : ob[7:0]};
			wt(pwi_pkg::OFS_OUTBUF, d, be);
			@(negedge clk);
			chk(32'(data_out), 32'(ob));
			chk(32'(new_data_strobe), 32'h1);
		end
		// Loopback with command lines echoed by the device
		wt(pwi_pkg::OFS_CSR, 32'h13, 4'hF);
		d = $random(seed);
		ob = d[15:0];
		wt(pwi_pkg::OFS_OUTBUF, d, 4'hF);
		rd(pwi_pkg::OFS_INBUF, {16'h0, ob});
		rd(pwi_pkg::OFS_CSR, 32'h0313);
		chk(32'(user_cmd), 32'h3);
		// Device input word and the input-taken pulse
		wt(pwi_pkg::OFS_CSR, 32'h0, 4'hF);
		d = $random(seed);
		dev_word <= d[15:0];
		repeat (6) @(posedge clk);
		rd(pwi_pkg::OFS_INBUF, {16'h0, d[15:0]});
		@(negedge clk);
		chk(32'(input_taken_strobe), 32'h1);
		repeat (STB) @(negedge clk);
		chk(32'(input_taken_strobe), 32'h0);
		// Vectored requests A then B
		wt(pwi_pkg::OFS_CSR, 32'h40, 4'hF);
		dev_req <= 2'h1;
		repeat (5) @(negedge clk);
		chk(32'(vec_irq), 32'h1AC0);
		rd(pwi_pkg::OFS_CSR, 32'h00C0);
		wt(pwi_pkg::OFS_CSR, 32'h0, 4'hF);
		@(negedge clk);
		chk(32'(vec_irq.req), 32'h0);
		@(posedge clk);
		dev_req <= 2'h2;
		wt(pwi_pkg::OFS_CSR, 32'h20, 4'hF);
		repeat (4) @(negedge clk);
		chk(32'(vec_irq), 32'h1AC4);
		// Reset in mid-run clears the enables
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(negedge clk);
		chk(32'(init_out), 32'h1);
		@(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		rd(pwi_pkg::OFS_CSR, 32'h8000);
		// Let the watcher take the last read before closing
		@(negedge clk);
		results();
	end
endmodule

bind pwi_port pwi_checker #(.STROBE_CYC(STROBE_CYC), .IRQ_LEVEL(IRQ_LEVEL),
	.IRQ_VECTOR(IRQ_VECTOR)) u_chk (.*);
